/* File: bench/immr_master_model.sv */
`timescale 1ns/1ns
// ****************
// Bus master model
// ****************
module immr_master_model
(
	input  wire logic           clk_sys,
	output immr_pkg::immr_req_t req
);
	import immr_pkg::*;

	initial
	begin
		req = '0;
	end

	// One request, then idle with scrambled fields
	task automatic access(input logic [31:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_sys);
		req <= '{1'b1, w, a, d};
		@(posedge clk_sys);
		req <= '{1'b0, ~w, ~a, ~d};
		#1;
	endtask
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ns
// ****************
// Testbench
// ****************
module tb;
	import immr_pkg::*;
	logic          clk_sys = 1'b0;
	logic          srst = 1'b1;
	immr_variant_t variant = IMMR_VAR_DUAL;
	immr_req_t     req;
	immr_nvcmd_t   nvcmd = '0;
	logic          remap_cmd = 1'b0;
	logic          erase_pin = 1'b0;
	immr_route_t   route_q;
	logic [16:0]   flash_word_q;
	logic          flash_plane_q;
	logic          abort_q;
	logic          remapped_q;
	logic [2:0]    nvbits_q;
	logic          bod_enable_q;
	logic [31:0]   wbuf_rdata_q;
	logic          wbuf_full_q;
	logic [31:0]   rnd = 32'h714C85B1;
	logic [31:0]   page[$];
	logic [2:0]    nv = 3'h0;
	logic          rm = 1'b0;
	int            failures = 0;
	int            comparisons = 0;

	always #2 clk_sys = ~clk_sys;

	immr_decoder immr_decoder_i
	(
		.clk_sys, .srst, .variant, .req, .nvcmd, .remap_cmd, .erase_pin, .route_q,
		.flash_word_q, .flash_plane_q, .abort_q, .remapped_q, .nvbits_q,
		.bod_enable_q, .wbuf_rdata_q, .wbuf_full_q
	);

	immr_master_model immr_master_model_i
	(
		.clk_sys, .req
	);

	// ****************
	// Helpers
	// ****************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic do_reset(input immr_variant_t vr);
		@(posedge clk_sys);
		srst <= 1'b1;
		variant <= vr;
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		rm = 1'b0;
		#1;
		check(32'(remapped_q), 32'h0);
		check(32'(route_q), 32'h0);
		check(32'(abort_q), 32'h0);
	endtask

	task automatic nv_cmd(input logic set, input logic [1:0] b);
		@(posedge clk_sys);
		nvcmd <= '{set, ~set, b};
		@(posedge clk_sys);
		nvcmd <= '0;
		nv[b] = set;
		#1;
		check(32'(nvbits_q[b]), 32'(set));
		@(posedge clk_sys);
		#1;
		check(32'(bod_enable_q), 32'(!nv[0]));
	endtask

	task automatic sweep(input int n);
		logic [31:0] a;
		immr_sel_t   es;
		logic [19:0] off;
		logic [19:0] fm;
		logic [19:0] sm;
		fm = variant == IMMR_VAR_DUAL ? 20'h7FFFF : variant == IMMR_VAR_MID ? 20'h3FFFF : 20'h07FFF;
		sm = (variant == IMMR_VAR_SML ? SRAM_BYTES_SML : SRAM_BYTES_BIG) - 20'h1;
		repeat (n)
		begin
			rnd = lfsr(rnd);
			a = rnd;
			if (!(rnd[30] & rnd[29]))
				a[31:28] = AREA_INTERNAL;
			if (!rnd[28])
				a[27:20] = {6'h00, rnd[21:20]};
			es = IMMR_SEL_NONE;
			if (a[31:28] == AREA_INTERNAL)
				case (a[27:20])
					WIN_BOOT:  es = rm ? IMMR_SEL_SRAM : nv[2] ? IMMR_SEL_FLASH : IMMR_SEL_ROM;
					WIN_FLASH: es = IMMR_SEL_FLASH;
					WIN_SRAM:  es = IMMR_SEL_SRAM;
					WIN_ROM:   es = IMMR_SEL_ROM;
					default:   es = IMMR_SEL_ABORT;
				endcase
			off = a[19:0] & (es == IMMR_SEL_FLASH ? fm : es == IMMR_SEL_SRAM ? sm : 20'hFFFFF);
			immr_master_model_i.access(a, 1'b0, rnd);
			check(32'(route_q.sel), 32'(es));
			check(32'(abort_q), 32'(es == IMMR_SEL_ABORT));
			if (es == IMMR_SEL_NONE)
				check(32'(route_q.valid), 32'h0);
			if (es != IMMR_SEL_ABORT && es != IMMR_SEL_NONE)
				check(32'(route_q.offset), 32'(off));
			if (es == IMMR_SEL_FLASH)
				check(32'(flash_word_q), 32'(off[18:2]));
			if (es == IMMR_SEL_FLASH)
				check(32'(flash_plane_q), 32'(variant == IMMR_VAR_DUAL && off[18]));
		end
	endtask

	task automatic wbuf_test();
		int words;
		words = (variant == IMMR_VAR_SML ? PAGE_BYTES_SML : PAGE_BYTES_BIG) / 4;
		page.delete();
		for (int i = 0; i < words; i++)
		begin
			check(32'(wbuf_full_q), 32'h0);
			rnd = lfsr(rnd);
			page.push_back(rnd);
			immr_master_model_i.access(BASE_FLASH + 32'(i * 4), 1'b1, rnd);
		end
		for (int i = 0; i < words; i++)
		begin
			immr_master_model_i.access(BASE_FLASH + 32'(i * 4), 1'b0, 32'h0);
			check(wbuf_rdata_q, page[i]);
		end
		check(32'(wbuf_full_q), 32'h1);
	endtask

	// ****************
	// Main sequence
	// ****************
	initial
	begin
		for (int v = 0; v < 3; v++)
		begin
			do_reset(immr_variant_t'(v));
			for (int b = 0; b < 3; b++)
				nv_cmd(1'b0, 2'(b));
			nv_cmd(1'b1, 2'h1);
			wbuf_test();
			sweep(48);
			nv_cmd(1'b1, 2'h2);
			nv_cmd(1'b1, 2'h0);
			sweep(48);
			@(posedge clk_sys);
			remap_cmd <= 1'b1;
			@(posedge clk_sys);
			remap_cmd <= 1'b0;
			rm = 1'b1;
			#1;
			check(32'(remapped_q), 32'h1);
			sweep(48);
			do_reset(variant);
			sweep(32);
			@(posedge clk_sys);
			erase_pin <= 1'b1;
			repeat (8) @(posedge clk_sys);
			erase_pin <= 1'b0;
			nv[2] = 1'b0;
			repeat (2) @(posedge clk_sys);
			#1;
			check(32'(nvbits_q[2]), 32'h0);
			sweep(32);
			$display("Variant %0d map test done", v);
		end
		tally_and_finish();
	end

	initial
	begin
		#200000;
		failures++;
		tally_and_finish();
	end
endmodule

/* File: src/immr_decoder.sv */
`timescale 1ns/1ns
// Overview of operation
// - Before remap, SRAM only at its window
// - After remap, SRAM also at zero
// - ROM always at its fixed window
// - Flash always at its fixed window
// - Pre-remap zero shows flash or ROM
// - Erase input clears boot bit
// - Set/clear commands update boot bits
// - SRAM decode limited to implemented size
// - Dual flash: two planes, word reads
// - Mid flash: one plane, word reads
// - Small flash: 256 pages, word reads
// - Page write buffer, 32-bit access
// - Boot bit 0 set disables brownout detector
// - Remap command puts SRAM at zero
// - Area zero split in 1 MB windows
module immr_decoder
(
	input  wire logic                    clk_sys,
	input  wire logic                    srst,
	input  wire immr_pkg::immr_variant_t variant,
	input  wire immr_pkg::immr_req_t     req,
	input  wire immr_pkg::immr_nvcmd_t   nvcmd,
	input  wire logic                    remap_cmd,
	input  wire logic                    erase_pin,
	output immr_pkg::immr_route_t        route_q,
	output logic      [16:0]             flash_word_q,
	output logic                         flash_plane_q,
	output logic                         abort_q,
	output logic                         remapped_q,
	output logic      [2:0]              nvbits_q,
	output logic                         bod_enable_q,
	output logic      [31:0]             wbuf_rdata_q,
	output logic                         wbuf_full_q
);
	import immr_pkg::*;

	// ****************************************
	// Helper functions
	// ****************************************
	function automatic logic [19:0] sram_size(input immr_variant_t v);
		sram_size = (v == IMMR_VAR_SML) ? SRAM_BYTES_SML : SRAM_BYTES_BIG;
	endfunction

	function automatic logic [19:0] flash_size(input immr_variant_t v);
		case (v)
			IMMR_VAR_DUAL: flash_size = 20'(WORDS_DUAL * 4 - 1);
			IMMR_VAR_MID:  flash_size = 20'(WORDS_MID * 4 - 1);
			IMMR_VAR_SML:  flash_size = 20'(WORDS_SML * 4 - 1);
			default:       flash_size = 20'(WORDS_SML * 4 - 1);
		endcase
	endfunction

	// ****************************************
	// Erase pin synchroniser
	// ****************************************
	logic erase_s1_q;
	logic erase_s2_q;
	logic erase_s3_q;
	logic erase_q;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			erase_s1_q <= 1'b0;
			erase_s2_q <= 1'b0;
			erase_s3_q <= 1'b0;
			erase_q    <= 1'b0;
		end
		else
		begin
			erase_s1_q <= erase_pin;
			erase_s2_q <= erase_s1_q;
			erase_s3_q <= erase_s2_q;
			if (erase_s2_q == erase_s3_q)
			begin
				erase_q <= erase_s2_q;
			end
		end
	end

	// ****************************************
	// Nonvolatile boot bits
	// ****************************************
	logic [2:0] nv_d;

	always_comb
	begin
		nv_d = nvbits_q;
		if (nvcmd.clr_cmd && (nvcmd.bit_idx < 2'(NVB_W)))
		begin
			nv_d[nvcmd.bit_idx] = 1'b0;
		end
		if (nvcmd.set_cmd && (nvcmd.bit_idx < 2'(NVB_W)))
		begin
			nv_d[nvcmd.bit_idx] = 1'b1;
		end
		if (erase_q)
		begin
			nv_d[NVB_BOOT_BIT] = 1'b0;
		end
	end

	// Boot bits survive core reset (nonvolatile)
	always_ff @(posedge clk_sys)
	begin
		nvbits_q     <= nv_d;
		bod_enable_q <= ~nv_d[NVB_BOD_BIT];
	end

	// ****************************************
	// Remap state
	// ****************************************
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			remapped_q <= 1'b0;
		end
		else if (remap_cmd)
		begin
			remapped_q <= 1'b1;
		end
	end

	// ****************************************
	// Address decode
	// ****************************************
	immr_route_t rt_d;
	logic [7:0]  win;
	logic [19:0] off;
	logic        in_area;

	assign win     = req.addr[27:20];
	assign off     = req.addr[19:0];
	assign in_area = (req.addr[31:28] == AREA_INTERNAL);

	always_comb
	begin
		rt_d        = '0;
		rt_d.valid  = req.valid && in_area;
		rt_d.offset = off;
		rt_d.sel    = IMMR_SEL_ABORT;
		case (win)
			WIN_BOOT:
			begin
				if (remapped_q)
				begin
					rt_d.sel = IMMR_SEL_SRAM;
				end
				else if (nvbits_q[NVB_BOOT_BIT])
				begin
					rt_d.sel = IMMR_SEL_FLASH;
				end
				else
				begin
					rt_d.sel = IMMR_SEL_ROM;
				end
			end
			WIN_FLASH: rt_d.sel = IMMR_SEL_FLASH;
			WIN_SRAM:  rt_d.sel = IMMR_SEL_SRAM;
			WIN_ROM:   rt_d.sel = IMMR_SEL_ROM;
			default:   rt_d.sel = IMMR_SEL_ABORT;
		endcase
		if (rt_d.sel == IMMR_SEL_SRAM)
		begin
			rt_d.offset = off & (sram_size(variant) - 20'h0_0001);
		end
		if (rt_d.sel == IMMR_SEL_FLASH)
		begin
			rt_d.offset = off & flash_size(variant);
		end
		if (!rt_d.valid)
		begin
			rt_d.sel = IMMR_SEL_NONE;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			route_q       <= '0;
			abort_q       <= 1'b0;
			flash_word_q  <= 17'h0_0000;
			flash_plane_q <= 1'b0;
		end
		else
		begin
			route_q       <= rt_d;
			abort_q       <= (rt_d.sel == IMMR_SEL_ABORT);
			flash_word_q  <= rt_d.offset[18:2];
			flash_plane_q <= (variant == IMMR_VAR_DUAL) && rt_d.offset[18];
		end
	end

	// ****************************************
	// Flash page write buffer
	// ****************************************
	logic       wb_wr;
	logic [7:0] wb_idx;

	assign wb_wr  = rt_d.valid && req.write && (rt_d.sel == IMMR_SEL_FLASH);
	assign wb_idx = {2'h0, rt_d.offset[7:2]};

	immr_wbuf u_wbuf
	(
		.clk_sys   (clk_sys),
		.srst      (srst),
		.variant   (variant),
		.wr_en     (wb_wr),
		.wr_word   (wb_idx),
		.wr_data   (req.wdata),
		.rd_word   (wb_idx),
		.rd_data_q (wbuf_rdata_q),
		.full_q    (wbuf_full_q)
	);

	// ****************************************
	// Checks
	// ****************************************
	rom_fixed_a: assert property (@(posedge clk_sys) disable iff (srst)
		req.valid && req.addr[31:20] == 12'h003 |=> route_q.sel == IMMR_SEL_ROM)
		else $error("ROM window misrouted");
	flash_fixed_a: assert property (@(posedge clk_sys) disable iff (srst)
		req.valid && req.addr[31:20] == 12'h001 |=> route_q.sel == IMMR_SEL_FLASH)
		else $error("Flash window misrouted");
	sram_window_a: assert property (@(posedge clk_sys) disable iff (srst)
		req.valid && req.addr[31:20] == 12'h002 |=> route_q.sel == IMMR_SEL_SRAM)
		else $error("SRAM window misrouted");
	zero_boot_a: assert property (@(posedge clk_sys) disable iff (srst)
		req.valid && req.addr[31:20] == 12'h000 && !remapped_q
		|=> route_q.sel == ($past(nvbits_q[2]) ? IMMR_SEL_FLASH : IMMR_SEL_ROM))
		else $error("Boot zero selection wrong");
	remap_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
		remapped_q && req.valid && req.addr[31:20] == 12'h000 |=> route_q.sel == IMMR_SEL_SRAM)
		else $error("Remapped zero not SRAM");
	remap_set_a: assert property (@(posedge clk_sys) disable iff (srst)
		remap_cmd |=> remapped_q)
		else $error("Remap not taken");
	abort_hole_a: assert property (@(posedge clk_sys) disable iff (srst)
		req.valid && req.addr[31:28] == 4'h0 && req.addr[27:22] != 6'h00 |=> abort_q)
		else $error("Hole not aborted");
	erase_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
		erase_q |=> !nvbits_q[2])
		else $error("Erase did not clear boot bit");
	nv_set_a: assert property (@(posedge clk_sys) disable iff (srst)
		nvcmd.set_cmd && nvcmd.bit_idx == 2'h0 |=> nvbits_q[0] && !bod_enable_q)
		else $error("Set command lost");
	sram_size_a: assert property (@(posedge clk_sys) disable iff (srst)
		route_q.sel == IMMR_SEL_SRAM && variant == IMMR_VAR_SML |-> route_q.offset[19:13] == 7'h00)
		else $error("SRAM offset beyond size");

	// ****************************************
	// Size and boot state checks
	// ****************************************
	sram_big_a: assert property (@(posedge clk_sys) disable iff (srst)
		route_q.sel == IMMR_SEL_SRAM && variant != IMMR_VAR_SML
		|-> route_q.offset[19:15] == 5'h00)
		else $error("Large SRAM offset beyond size");
	flash_dual_a: assert property (@(posedge clk_sys) disable iff (srst)
		route_q.sel == IMMR_SEL_FLASH && variant == IMMR_VAR_DUAL |-> !route_q.offset[19])
		else $error("Dual flash offset beyond size");
	flash_mid_a: assert property (@(posedge clk_sys) disable iff (srst)
		route_q.sel == IMMR_SEL_FLASH && variant == IMMR_VAR_MID
		|-> route_q.offset[19:18] == 2'h0)
		else $error("Mid flash offset beyond size");
	flash_small_a: assert property (@(posedge clk_sys) disable iff (srst)
		route_q.sel == IMMR_SEL_FLASH && variant == IMMR_VAR_SML
		|-> route_q.offset[19:15] == 5'h00)
		else $error("Small flash offset beyond size");
	plane_single_a: assert property (@(posedge clk_sys) disable iff (srst)
		variant != IMMR_VAR_DUAL |-> !flash_plane_q)
		else $error("Plane bit on single plane flash");
	flash_word_a: assert property (@(posedge clk_sys) disable iff (srst)
		route_q.sel == IMMR_SEL_FLASH
		|-> flash_word_q == route_q.offset[18:2])
		else $error("Flash word index wrong");
	rom_offset_a: assert property (@(posedge clk_sys) disable iff (srst)
		req.valid && req.addr[31:20] == 12'h003
		|=> route_q.offset == $past(req.addr[19:0]))
		else $error("ROM offset altered");
	outside_area_a: assert property (@(posedge clk_sys) disable iff (srst)
		req.valid && req.addr[31:28] != 4'h0 |=> !route_q.valid && !abort_q)
		else $error("Outside access decoded");
	sram_zero_pre_a: assert property (@(posedge clk_sys) disable iff (srst)
		req.valid && req.addr[31:20] == 12'h000 && !remapped_q
		|=> route_q.sel != IMMR_SEL_SRAM)
		else $error("SRAM at zero before remap");
	remap_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
		remapped_q |=> remapped_q)
		else $error("Remap state lost");
	nv_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
		nvcmd.clr_cmd && !nvcmd.set_cmd && nvcmd.bit_idx == 2'h1
		|=> !nvbits_q[1])
		else $error("Clear command lost");
	nv_set_boot_a: assert property (@(posedge clk_sys) disable iff (srst)
		nvcmd.set_cmd && nvcmd.bit_idx == 2'h2 && !erase_q
		|=> nvbits_q[2])
		else $error("Boot bit set lost");
	abort_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
		!route_q.valid |-> !abort_q)
		else $error("Abort without request");

endmodule

/* File: src/immr_pkg.sv */
package immr_pkg;

	// ****************************************
	// Address map
	// ****************************************
	localparam int          ADDR_W          = 32;
	localparam logic [3:0]  AREA_INTERNAL   = 4'h0;
	localparam logic [7:0]  WIN_BOOT        = 8'h00;
	localparam logic [7:0]  WIN_FLASH       = 8'h01;
	localparam logic [7:0]  WIN_SRAM        = 8'h02;
	localparam logic [7:0]  WIN_ROM         = 8'h03;
	localparam logic [31:0] BASE_FLASH      = 32'h0010_0000;
	localparam logic [31:0] BASE_SRAM       = 32'h0020_0000;
	localparam logic [31:0] BASE_ROM        = 32'h0030_0000;

	// ****************************************
	// Memory sizes per variant
	// ****************************************
	localparam logic [19:0] SRAM_BYTES_BIG  = 20'h0_8000;
	localparam logic [19:0] SRAM_BYTES_SML  = 20'h0_2000;
	localparam int          FLASH_PAGES_BIG = 1024;
	localparam int          FLASH_PAGES_SML = 256;
	localparam int          PAGE_BYTES_BIG  = 256;
	localparam int          PAGE_BYTES_SML  = 128;
	localparam int          WORDS_DUAL      = 131072;
	localparam int          WORDS_MID       = 65536;
	localparam int          WORDS_SML       = 8192;
	localparam int          WBUF_WORDS_MAX  = 64;

	// ****************************************
	// Nonvolatile boot bits
	// ****************************************
	localparam int          NVB_W           = 3;
	localparam int          NVB_BOD_BIT     = 0;
	localparam int          NVB_BOOT_BIT    = 2;
	localparam logic [2:0]  NVB_RESET       = 3'h0;

	typedef enum logic [1:0]
	{
		IMMR_VAR_DUAL = 2'b00,
		IMMR_VAR_MID  = 2'b01,
		IMMR_VAR_SML  = 2'b10
	} immr_variant_t;

	typedef enum logic [2:0]
	{
		IMMR_SEL_NONE  = 3'b000,
		IMMR_SEL_FLASH = 3'b001,
		IMMR_SEL_SRAM  = 3'b010,
		IMMR_SEL_ROM   = 3'b011,
		IMMR_SEL_ABORT = 3'b100
	} immr_sel_t;

	typedef struct packed
	{
		logic        valid;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} immr_req_t;

	typedef struct packed
	{
		logic        valid;
		immr_sel_t   sel;
		logic [19:0] offset;
	} immr_route_t;

	typedef struct packed
	{
		logic                set_cmd;
		logic                clr_cmd;
		logic [1:0]          bit_idx;
	} immr_nvcmd_t;

endpackage

/* File: src/immr_wbuf.sv */
`timescale 1ns/1ns
module immr_wbuf
(
	input  wire logic                 clk_sys,
	input  wire logic                 srst,
	input  wire immr_pkg::immr_variant_t variant,
	input  wire logic                 wr_en,
	input  wire logic [7:0]           wr_word,
	input  wire logic [31:0]          wr_data,
	input  wire logic [7:0]           rd_word,
	output logic      [31:0]          rd_data_q,
	output logic                      full_q
);
	import immr_pkg::*;

	logic [31:0] mem_q [WBUF_WORDS_MAX];
	logic [6:0]  cnt_q;
	logic [6:0]  limit;

	// ****************************************
	// Page buffer, 32-bit access
	// ****************************************
	assign limit = (variant == IMMR_VAR_SML) ? 7'(PAGE_BYTES_SML / 4) : 7'(PAGE_BYTES_BIG / 4);

	always_ff @(posedge clk_sys)
	begin
		if (wr_en && (7'(wr_word) < limit))
		begin
			mem_q[wr_word[5:0]] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			cnt_q <= 7'h00;
		end
		else if (wr_en && (7'(wr_word) < limit) && (cnt_q < limit))
		begin
			cnt_q <= cnt_q + 7'h01;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			rd_data_q <= 32'h0000_0000;
			full_q    <= 1'b0;
		end
		else
		begin
			rd_data_q <= (7'(rd_word) < limit) ? mem_q[rd_word[5:0]] : 32'h0000_0000;
			full_q    <= (cnt_q >= limit);
		end
	end

endmodule
